/* audio_in.sv */
// Bypass and bitstream audio input front end with its control registers.
// Assumes pins are asynchronous and pass two flip-flops before use.
`timescale 1ns/100ps
`include "audio_in_cfg.svh"
module audio_in
	import audio_in_pkg::*;
(
	input  wire logic        mclk_i,
	input  wire logic        rst_b_i,
	input  wire logic        frame_clock_i,
	input  wire logic        serial_bit_clock_i,
	input  wire logic        data_pin_i,
	input  wire logic        mute_pin_i,
	input  wire logic        sys_clock_pin_i,
	input  wire logic        reg_wr_i,
	input  wire logic [6:0]  reg_idx_i,
	input  wire logic [7:0]  reg_wdata_i,
	output logic      [7:0]  reg_rdata_o,
	output logic      [23:0] left_sample_o,
	output logic      [23:0] right_sample_o,
	output logic             sample_valid_o,
	output logic             left_bitstream_o,
	output logic             right_bitstream_o,
	output logic             bit_valid_o,
	output logic      [1:0]  fir_response_o,
	output logic      [1:0]  modulator_rate_o,
	output logic      [4:0]  oversample_mult_o,
	output logic             left_zero_flag_o,
	output logic             right_zero_flag_o
);
	logic [7:0] ctrl_word_a;
	logic [7:0] ctrl_word_b;
	logic [7:0] input_format_ctrl;
	logic [7:0] channel_option_ctrl;
	logic [7:0] operating_mode_ctrl;
	logic [7:0] zero_flag_enable_ctrl;
	logic [7:0] zero_flag_status;
	mode_t      mode;
	mode_t      next_mode;
	logic [2:0] pin_raw;
	logic [2:0] pin_s;
	logic       ser_s;
	logic       mute_s;
	logic [2:0] pin_d;

	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rst_b_i);

	// Frame, bit clock, data, mute and system clock pins
	pin_sync_if fr_if();
	pin_sync_if bk_if();
	pin_sync_if dt_if();
	pin_sync_if mu_if();
	pin_sync_if sk_if();
	assign fr_if.raw = frame_clock_i;
	assign bk_if.raw = serial_bit_clock_i;
	assign dt_if.raw = data_pin_i;
	assign mu_if.raw = mute_pin_i;
	assign sk_if.raw = sys_clock_pin_i;
	pin_sync u_fr (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .p(fr_if));
	pin_sync u_bk (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .p(bk_if));
	pin_sync u_dt (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .p(dt_if));
	pin_sync u_mu (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .p(mu_if));
	pin_sync u_sk (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .p(sk_if));
	assign pin_s  = {sk_if.synced, bk_if.synced, fr_if.synced};
	assign ser_s  = dt_if.synced;
	assign mute_s = mu_if.synced;
	assign pin_raw = pin_s;

	logic fr_s;
	logic bk_s;
	logic sk_s;
	logic bk_rise;
	logic fr_fall;
	logic sk_rise;
	assign fr_s = pin_s[0];
	assign bk_s = pin_s[1];
	assign sk_s = pin_s[2];
	// Edges found by sampling, so no fixed phase to mclk is needed
	assign bk_rise = bk_s & ~pin_d[1]; // see RQ2
	assign fr_fall = ~fr_s & pin_d[0]; // see RQ2
	assign sk_rise = sk_s & ~pin_d[2]; // see RQ14

	always_ff @(posedge mclk_i) begin
		if (!rst_b_i)
			pin_d <= 3'h0;
		else
			pin_d <= pin_raw;
	end

	// Register port: bits unavailable in bypass mode are never stored
	logic system_reset_cmd_pulse;
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i || system_reset_cmd_pulse) begin
			ctrl_word_a           <= 8'h00;
			ctrl_word_b           <= 8'h00;
			input_format_ctrl     <= {1'b0, `FMT_RST, 4'h0};
			channel_option_ctrl   <= 8'h00;
			operating_mode_ctrl   <= 8'h00;
			zero_flag_enable_ctrl <= `ZEN_RST;
		end else if (reg_wr_i) begin // see RQ8
			case (reg_idx_i)
				`REG_A_IDX:    ctrl_word_a <= reg_wdata_i;
				`REG_B_IDX:    ctrl_word_b <= reg_wdata_i;
				`REG_FMT_IDX:  input_format_ctrl <= reg_wdata_i & 8'h7C;
				`REG_CHAN_IDX: channel_option_ctrl <= reg_wdata_i & 8'h91;
				`REG_MODE_IDX: operating_mode_ctrl <= reg_wdata_i & 8'h3F;
				`REG_ZEN_IDX:  zero_flag_enable_ctrl <= reg_wdata_i & 8'h07;
				default: ;
			endcase
		end
	end

	// Soft reset is a self-clearing command
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i)
			system_reset_cmd_pulse <= 1'b0;
		else
			system_reset_cmd_pulse <= reg_wr_i && reg_idx_i == `REG_MODE_IDX
				&& reg_wdata_i[`SYSTEM_RESET_CMD_BIT];
	end

	logic bitstream_mode_en;
	logic filter_bypass_en;
	logic [2:0] input_format_sel;
	logic [1:0] modulator_rate_sel;
	logic [1:0] fir_response_sel;
	logic mono_sel;
	logic sample_zero_flag_en;
	assign bitstream_mode_en   = operating_mode_ctrl[`DSD_BIT];
	assign filter_bypass_en    = operating_mode_ctrl[`FILTER_BYPASS_EN_BIT];
	assign input_format_sel    = input_format_ctrl[`FMT_LSB +: 3];
	assign modulator_rate_sel  = operating_mode_ctrl[`OS_LSB +: 2];
	assign fir_response_sel    = input_format_ctrl[`DMF_LSB +: 2];
	assign mono_sel            = operating_mode_ctrl[`MONO_BIT];
	assign sample_zero_flag_en = zero_flag_enable_ctrl[`SAMPLE_ZERO_FLAG_EN_BIT];

	// Bitstream mode takes precedence; host must set it before data flows
	always_comb begin
		if (bitstream_mode_en)
			next_mode = MODE_STREAM; // see RQ9 see RQ11
		else if (filter_bypass_en)
			next_mode = MODE_BYPASS; // see RQ17
		else
			next_mode = MODE_NORMAL;
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_b_i)
			mode <= MODE_NORMAL;
		else
			mode <= next_mode;
	end

	// Bypass receiver
	logic [23:0] left_shift;
	logic [23:0] right_shift;
	logic [23:0] left_word;
	logic [23:0] right_word;
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			left_shift  <= 24'h0;
			right_shift <= 24'h0;
		end else if (mode == MODE_BYPASS && bk_rise) begin
			left_shift  <= {left_shift[22:0], ser_s}; // see RQ19 see RQ21
			right_shift <= {right_shift[22:0], mute_s}; // see RQ19
		end
	end

	// Right-justified: the last N bits before the word edge form the word
	always_comb begin
		case (input_format_sel)
			FMT_20: begin
				left_word  = {{4{left_shift[19]}}, left_shift[19:0]};
				right_word = {{4{right_shift[19]}}, right_shift[19:0]};
			end
			FMT_24: begin
				left_word  = left_shift;
				right_word = right_shift;
			end
			default: begin
				left_word  = {{8{left_shift[15]}}, left_shift[15:0]};
				right_word = {{8{right_shift[15]}}, right_shift[15:0]};
			end
		endcase // see RQ3
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			left_sample_o  <= 24'h0;
			right_sample_o <= 24'h0;
			sample_valid_o <= 1'b0;
		end else begin
			sample_valid_o <= mode == MODE_BYPASS && fr_fall;
			if (mode == MODE_BYPASS && fr_fall) begin
				left_sample_o  <= left_word; // see RQ21
				right_sample_o <= right_word;
			end
		end
	end

	// Bitstream receiver: data pin left or mono, frame pin right
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			left_bitstream_o  <= 1'b0;
			right_bitstream_o <= 1'b0;
			bit_valid_o       <= 1'b0;
		end else begin
			bit_valid_o <= mode == MODE_STREAM && sk_rise; // see RQ22
			if (mode == MODE_STREAM && sk_rise) begin
				left_bitstream_o  <= ser_s; // see RQ12
				right_bitstream_o <= mono_sel ? ser_s : fr_s; // see RQ13
			end
		end
	end

	// Rate and filter controls; the multiple is the modulator rate alone
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			fir_response_o    <= `DMF_RST;
			modulator_rate_o  <= `OS_RST;
			oversample_mult_o <= 5'h08;
		end else begin
			fir_response_o   <= fir_response_sel; // see RQ10
			modulator_rate_o <= modulator_rate_sel; // see RQ4
			case (os_t'(modulator_rate_sel))
				OS_X4:   oversample_mult_o <= 5'h04; // see RQ5
				OS_X16:  oversample_mult_o <= 5'h10;
				default: oversample_mult_o <= 5'h08;
			endcase
		end
	end

	// Zero detect over a long run of zero words in bypass mode
	logic [11:0] zl_cnt;
	logic [11:0] zr_cnt;
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			zl_cnt <= 12'h0;
			zr_cnt <= 12'h0;
		end else if (sample_valid_o) begin
			zl_cnt <= |left_sample_o ? 12'h0
				: (zl_cnt == `ZERO_RUN ? zl_cnt : zl_cnt + 12'h1);
			zr_cnt <= |right_sample_o ? 12'h0
				: (zr_cnt == `ZERO_RUN ? zr_cnt : zr_cnt + 12'h1);
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			left_zero_flag_o  <= 1'b0;
			right_zero_flag_o <= 1'b0;
			zero_flag_status  <= 8'h00;
		end else begin
			left_zero_flag_o  <= sample_zero_flag_en && zl_cnt == `ZERO_RUN;
			right_zero_flag_o <= sample_zero_flag_en && zr_cnt == `ZERO_RUN;
			zero_flag_status  <= {6'h0, right_zero_flag_o,
				left_zero_flag_o}; // see RQ20
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_b_i)
			reg_rdata_o <= 8'h00;
		else begin
			case (reg_idx_i)
				`REG_A_IDX:    reg_rdata_o <= ctrl_word_a;
				`REG_B_IDX:    reg_rdata_o <= ctrl_word_b;
				`REG_FMT_IDX:  reg_rdata_o <= input_format_ctrl;
				`REG_CHAN_IDX: reg_rdata_o <= channel_option_ctrl;
				`REG_MODE_IDX: reg_rdata_o <= operating_mode_ctrl;
				`REG_ZEN_IDX:  reg_rdata_o <= zero_flag_enable_ctrl;
				`REG_ZST_IDX:  reg_rdata_o <= zero_flag_status;
				default:       reg_rdata_o <= 8'h00;
			endcase
		end
	end

	// Checks
	sequence s_stream_edge;
		mode == MODE_STREAM && sk_rise;
	endsequence
	sequence s_bypass_frame;
		mode == MODE_BYPASS && fr_fall;
	endsequence

	AST_STREAM_ENTRY: assert property (bitstream_mode_en // see RQ9
		|=> mode == MODE_STREAM)
		else $error("Bitstream mode not entered");
	AST_BYPASS_ENTRY: assert property (filter_bypass_en // see RQ17
		&& !bitstream_mode_en |=> mode == MODE_BYPASS)
		else $error("Bypass mode not entered");
	AST_FMT16: assert property (s_bypass_frame // see RQ3
		and input_format_sel == 3'h0
		|=> left_sample_o == {{8{$past(left_shift[15])}},
		$past(left_shift[15:0])})
		else $error("16-bit word wrong");
	AST_OS_MULT: assert property (modulator_rate_sel == 2'h2 // see RQ4
		|=> oversample_mult_o == 5'h10)
		else $error("Sixteen times rate missing");
	AST_FIR_SEL: assert property (##1 // see RQ10
		fir_response_o == $past(fir_response_sel))
		else $error("Filter response not followed");
	AST_LEFT_BIT: assert property (s_stream_edge // see RQ12
		|=> bit_valid_o && left_bitstream_o == $past(ser_s))
		else $error("Left bitstream wrong");
	AST_RIGHT_BIT: assert property (s_stream_edge // see RQ13
		and !mono_sel
		|=> right_bitstream_o == $past(fr_s))
		else $error("Right bitstream wrong");
	AST_NO_BIT_BYPASS: assert property (mode != MODE_STREAM // see RQ14
		|=> !bit_valid_o)
		else $error("Bit taken outside bitstream mode");
	AST_FRAME_LATCH: assert property (s_bypass_frame // see RQ21
		|=> sample_valid_o ##1 !sample_valid_o)
		else $error("Word not latched on frame edge");
	AST_ZERO_RD: assert property (left_zero_flag_o // see RQ20
		|=> zero_flag_status[0])
		else $error("Zero flag not mirrored");
	AST_MASKED: assert property (input_format_ctrl[7] == 1'b0 // see RQ8
		&& operating_mode_ctrl[7:6] == 2'h0)
		else $error("Unavailable bit stored");
endmodule // audio_in

/* audio_in_cfg.svh */
// Constants of the bypass / bitstream audio input block.
// Assumes the register port addresses registers by their printed index.
// Operation
// RQ1 - Source runs word-rate clock synchronous to the system clock.
// RQ2 - Any fixed phase between system clock and word-rate clock is accepted.
// RQ3 - Format field picks 16, 20 or 24 bit right-justified words.
// RQ4 - Modulator rate field: 00 eight, 01 four, 10 sixteen times.
// RQ5 - Total oversampling is filter factor times modulator rate; oversample_mult_o follows the modulator rate alone.
// RQ6 - Host avoids sixteen times rate above 100 kHz sampling.
// RQ7 - Sixteen times rate needs system clock above 256 fs.
// RQ8 - Bits unavailable in bypass mode have no effect.
// RQ9 - Bitstream enable bit in register 20 enters bitstream mode.
// RQ10 - Bitstream mode uses one of four filter responses from register 18.
// RQ11 - Bitstream enable must precede bitstream data, else command mode.
// RQ12 - Serial data pin carries left or single bitstream.
// RQ13 - Frame clock pin carries the right bitstream.
// RQ14 - System clock pin carries the bitstream bit clock.
// RQ15 - Serial bit clock pin held low in bitstream mode.
// RQ16 - Bitstream bit clock is an integer multiple of fs.
// RQ17 - Filter bypass bit in register 20 enters bypass mode.
// RQ18 - Word-rate clock runs at eight or four times fs.
// RQ19 - Left samples on data pin, right samples on mute pin.
// RQ20 - Zero flags read one when a channel zero is detected.
// RQ21 - Shift on rising bit clock, latch word at word clock boundary.
// RQ22 - One bit per channel per bitstream clock edge to the filter.
`ifndef AUDIO_IN_CFG_SVH
`define AUDIO_IN_CFG_SVH
`define REG_A_IDX      7'h10
`define REG_B_IDX      7'h11
`define REG_FMT_IDX    7'h12
`define REG_CHAN_IDX   7'h13
`define REG_MODE_IDX   7'h14
`define REG_ZEN_IDX    7'h15
`define REG_ZST_IDX    7'h16
`define FMT_LSB        4
`define DMF_LSB        2
`define OS_LSB         0
`define CHANNEL_PICK_BIT       2
`define MONO_BIT       3
`define FILTER_BYPASS_EN_BIT       4
`define DSD_BIT        5
`define SYSTEM_RESET_CMD_BIT       6
`define REV_BIT        7
`define OPE_BIT        4
`define INFINITE_ZERO_DETECT_OPT_BIT       0
`define SAMPLE_ZERO_FLAG_EN_BIT       0
`define FMT_RST        3'h0
`define OS_RST         2'h0
`define DMF_RST        2'h0
`define ZEN_RST        8'h01
`define ZERO_RUN       12'hFFF
`endif

/* audio_in_pkg.sv */
// Types shared by the audio input block.
// Assumes audio_in_cfg.svh carries the numbers.
package audio_in_pkg;
	typedef enum logic [2:0] {
		FMT_16 = 3'h0,
		FMT_20 = 3'h1,
		FMT_24 = 3'h2
	} fmt_t;
	typedef enum logic [1:0] {
		OS_X8  = 2'h0,
		OS_X4  = 2'h1,
		OS_X16 = 2'h2,
		OS_RSV = 2'h3
	} os_t;
	typedef enum logic [2:0] {
		MODE_NORMAL = 3'h1,
		MODE_BYPASS = 3'h2,
		MODE_STREAM = 3'h4
	} mode_t;
endpackage

/* pin_sync_if.sv */
// Carrier between the top block and its pin synchroniser.
// Assumes all signals live in the mclk_i domain after sync.
`timescale 1ns/100ps
interface pin_sync_if;
	logic raw;
	logic synced;
	modport src (output raw, input synced);
	modport snk (input raw, output synced);
endinterface

/* pin_sync.sv */
// Two flip-flop synchroniser for one pin.
// Assumes a clean pin level; first stage feeds only the second.
`timescale 1ns/100ps
module pin_sync (
	input  wire logic mclk_i,
	input  wire logic rst_b_i,
	pin_sync_if.snk   p
);
	logic stage1;
	logic stage2;
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			stage1 <= 1'b0;
			stage2 <= 1'b0;
		end else begin
			stage1 <= p.raw;
			stage2 <= stage1;
		end
	end
	assign p.synced = stage2;
endmodule // pin_sync

/* audio_src_model.sv */
// Behavioural far side: external interpolation filter or bitstream decoder.
// Assumes the bench calls one task at a time; pins idle low at time zero.
`timescale 1ns/100ps
module audio_src_model (
	output logic frame_clock_o,
	output logic serial_bit_clock_o,
	output logic data_pin_o,
	output logic mute_pin_o,
	output logic sys_clock_pin_o
);
	localparam int HALF = 80;
	initial begin
		frame_clock_o      = 1'b0;
		serial_bit_clock_o = 1'b0;
		data_pin_o         = 1'b0;
		mute_pin_o         = 1'b0;
		sys_clock_pin_o    = 1'b0;
	end
	// Word and bit clock share the bench reference with mclk_i
	// One word clock period per word, 24 slots, MSB first
	task automatic send_word(input logic [23:0] l, input logic [23:0] r);
		frame_clock_o = 1'b1;
		for (int i = 23; i >= 0; i--) begin
			data_pin_o = l[i];
			mute_pin_o = r[i];
			#HALF serial_bit_clock_o = 1'b1;
			#HALF serial_bit_clock_o = 1'b0;
		end
		#40 frame_clock_o = 1'b0;
		// Released lines flip so a stale bit can never look valid
		data_pin_o = ~l[0];
		mute_pin_o = ~r[0];
	endtask
	// Bit clock stands still between calls
	task automatic send_bits(input logic l, input logic r);
		serial_bit_clock_o = 1'b0;
		data_pin_o         = l;
		frame_clock_o      = r;
		#HALF sys_clock_pin_o = 1'b1;
		#HALF sys_clock_pin_o = 1'b0;
		#20 data_pin_o = ~l;
		frame_clock_o = ~r;
	endtask
endmodule // audio_src_model

/* tb_audio_in.sv */
// Self-checking bench for the audio input block.
// Assumes audio_src_model drives the pins with a 160 ns link clock.
`timescale 1ns/100ps
`include "audio_in_cfg.svh"
module tb_audio_in;
	import audio_in_pkg::*;
	typedef struct packed {
		logic [6:0] idx;
		logic [7:0] wdata;
		logic [7:0] exp;
	} row_t;
	localparam logic [7:0] PAT = 8'hB4;
	logic        mclk_i, rst_b_i, reg_wr_i;
	logic [6:0]  reg_idx_i;
	logic [7:0]  reg_wdata_i, reg_rdata_o, r;
	logic        frame_clock_i, serial_bit_clock_i, data_pin_i;
	logic        mute_pin_i, sys_clock_pin_i;
	logic [23:0] left_sample_o, right_sample_o;
	logic        sample_valid_o, left_bitstream_o, right_bitstream_o;
	logic        bit_valid_o, left_zero_flag_o, right_zero_flag_o;
	logic [1:0]  fir_response_o, modulator_rate_o;
	logic [4:0]  oversample_mult_o;
	int          fail_count, n_tests, cycles;
	int          mult [3] = '{8, 4, 16};
	logic [6:0]  ridx [4] = '{7'h12, 7'h14, 7'h15, 7'h16};
	logic [7:0]  rexp [4] = '{8'h00, 8'h00, 8'h01, 8'h00};
	// Masked writes, read-only and unmapped places
	row_t rows [7] = '{'{7'h12, 8'hFF, 8'h7C}, '{7'h13, 8'hFF, 8'h91},
		'{7'h15, 8'hFF, 8'h07}, '{7'h16, 8'hFF, 8'h00},
		'{7'h20, 8'hFF, 8'h00}, '{7'h13, 8'h00, 8'h00},
		'{7'h15, 8'h01, 8'h01}};
	audio_in DUT (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
		.frame_clock_i(frame_clock_i), .serial_bit_clock_i(serial_bit_clock_i),
		.data_pin_i(data_pin_i), .mute_pin_i(mute_pin_i),
		.sys_clock_pin_i(sys_clock_pin_i), .reg_wr_i(reg_wr_i),
		.reg_idx_i(reg_idx_i), .reg_wdata_i(reg_wdata_i),
		.reg_rdata_o(reg_rdata_o), .left_sample_o(left_sample_o),
		.right_sample_o(right_sample_o), .sample_valid_o(sample_valid_o),
		.left_bitstream_o(left_bitstream_o),
		.right_bitstream_o(right_bitstream_o), .bit_valid_o(bit_valid_o),
		.fir_response_o(fir_response_o), .modulator_rate_o(modulator_rate_o),
		.oversample_mult_o(oversample_mult_o),
		.left_zero_flag_o(left_zero_flag_o),
		.right_zero_flag_o(right_zero_flag_o));
	audio_src_model src (.frame_clock_o(frame_clock_i),
		.serial_bit_clock_o(serial_bit_clock_i), .data_pin_o(data_pin_i),
		.mute_pin_o(mute_pin_i), .sys_clock_pin_o(sys_clock_pin_i));
	initial begin
		mclk_i = 1'b0;
		forever #10 mclk_i = ~mclk_i;
	end
	task automatic chk(input string nm, input logic [23:0] seen,
			input logic [23:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		reg_wr_i    <= 1'b1;
		reg_idx_i   <= a;
		reg_wdata_i <= d;
		@(posedge mclk_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [6:0] a, output logic [7:0] d);
		@(posedge mclk_i);
		reg_idx_i <= a;
		repeat (2) @(posedge mclk_i);
		#1 d = reg_rdata_o;
	endtask
	// Bounded wait for a one-cycle valid pulse
	task automatic wait_valid(input bit stream);
		int n;
		n = 0;
		do begin
			@(posedge mclk_i);
			#1 n++;
		end while (((stream ? bit_valid_o : sample_valid_o) !== 1'b1)
			&& n < 400);
		if (n >= 400)
			chk("valid wait", 24'h0, 24'h1);
	endtask
	function automatic logic [23:0] sx(input logic [23:0] v, input int n);
		for (int i = n; i < 24; i++)
			v[i] = v[n - 1];
		return v;
	endfunction
	// Ceiling well above the roughly 800 cycles the sequence needs
	always @(posedge mclk_i) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			fail_count++;
			conclude();
		end
	end
	initial begin
		rst_b_i     = 1'b0;
		reg_wr_i    = 1'b0;
		reg_idx_i   = 7'h00;
		reg_wdata_i = 8'h00;
		fail_count  = 0;
		n_tests     = 0;
		cycles      = 0;
		repeat (12) @(posedge mclk_i);
		rst_b_i <= 1'b1;
		foreach (rows[i]) begin
			wr(rows[i].idx, rows[i].wdata);
			rd(rows[i].idx, r);
			chk("reg", {16'h0, r}, {16'h0, rows[i].exp});
		end
		for (int o = 0; o < 3; o++) begin
			wr(`REG_MODE_IDX, 8'h10 | 8'(o));
			rd(`REG_MODE_IDX, r);
			chk("mode reg", {16'h0, r}, 24'h10 | 24'(o));
			chk("rate", {22'h0, modulator_rate_o}, 24'(o));
			chk("mult", {19'h0, oversample_mult_o}, 24'(mult[o]));
		end
		wr(`REG_MODE_IDX, 8'h10);
		for (int f = 0; f < 3; f++) begin
			// Unavailable bits set alongside the format code
			wr(`REG_FMT_IDX, 8'(f << 4) | 8'h83);
			rd(`REG_FMT_IDX, r);
			chk("fmt reg", {16'h0, r}, 24'(f << 4));
			#(7 * f + 3);
			fork
				src.send_word(24'hA5C3E1, 24'h3C1A96);
				wait_valid(1'b0);
			join
			chk("left", left_sample_o, sx(24'hA5C3E1, 16 + 4 * f));
			chk("right", right_sample_o, sx(24'h3C1A96, 16 + 4 * f));
			chk("zero", {22'h0, left_zero_flag_o, right_zero_flag_o},
				24'h0);
		end
		// Stream mode is set before any stream bit moves
		wr(`REG_MODE_IDX, 8'h20);
		for (int d = 0; d < 4; d++) begin
			wr(`REG_FMT_IDX, 8'(d << 2));
			rd(`REG_FMT_IDX, r);
			chk("fir", {22'h0, fir_response_o}, 24'(d));
		end
		for (int i = 0; i < 8; i++) begin
			fork
				src.send_bits(PAT[i], ~PAT[i]);
				wait_valid(1'b1);
			join
			chk("bits", {22'h0, left_bitstream_o, right_bitstream_o},
				{22'h0, PAT[i], ~PAT[i]});
		end
		// Single-stream operation copies the data pin to both outputs
		wr(`REG_MODE_IDX, 8'h28);
		fork
			src.send_bits(1'b1, 1'b0);
			wait_valid(1'b1);
		join
		chk("mono", {22'h0, left_bitstream_o, right_bitstream_o},
			24'h3);
		@(posedge mclk_i);
		rst_b_i <= 1'b0;
		repeat (3) @(posedge mclk_i);
		rst_b_i <= 1'b1;
		#1 chk("mult rst", {19'h0, oversample_mult_o}, 24'h08);
		chk("fir rst", {22'h0, fir_response_o}, 24'h0);
		for (int i = 0; i < 4; i++) begin
			rd(ridx[i], r);
			chk("reg rst", {16'h0, r}, {16'h0, rexp[i]});
		end
		wr(`REG_FMT_IDX, 8'h1C);
		wr(`REG_MODE_IDX, 8'h40);
		rd(`REG_FMT_IDX, r);
		chk("soft rst", {16'h0, r}, 24'h0);
		chk("fir system_reset_cmd", {22'h0, fir_response_o}, 24'h0);
		conclude();
	end
endmodule // tb_audio_in
